// ===== include/dem_regs.svh
`ifndef DEM_REGS_SVH
`define DEM_REGS_SVH

// ************************************************************
// Register offsets, byte addresses on the APB port
// ************************************************************
`define DEM_ADDR_W 12
`define DEM_OFF_STATUS0 12'h0BC
`define DEM_OFF_STATUS1 12'h0C0
`define DEM_OFF_MASK0 12'h0C4
`define DEM_OFF_MASK1 12'h0C8
`define DEM_OFF_FORCE0 12'h0D8
`define DEM_OFF_FORCE1 12'h0DC
`define DEM_OFF_SHADOW 12'h100
`define DEM_OFF_VCID 12'h10C
`define DEM_OFF_COLOR 12'h110

// ************************************************************
// Field widths and positions
// ************************************************************
`define DEM_G0_W 21
`define DEM_G1_W 13
`define DEM_ACK_W 16
`define DEM_PHY_W 5
`define DEM_PHY_LSB 16
`define DEM_SH_EN_BIT 0
`define DEM_SH_REQ_BIT 8
`define DEM_SH_PIN_BIT 16
`define DEM_VCID_W 2
`define DEM_CODE_W 4
`define DEM_LOOSE_BIT 8

// Error group 1 bit positions
`define DEM_E1_HS_TO 0
`define DEM_E1_LP_TO 1
`define DEM_E1_ECC_SINGLE 2
`define DEM_E1_ECC_MULTI 3
`define DEM_E1_CRC 4
`define DEM_E1_PKT_SIZE 5
`define DEM_E1_EOTP 6
`define DEM_E1_PIX_OVF 7
`define DEM_E1_CMD_WR 8
`define DEM_E1_PLD_WR 9
`define DEM_E1_PLD_SEND 10
`define DEM_E1_PLD_RD 11
`define DEM_E1_PLD_RECV 12

// ************************************************************
// Reset values
// ************************************************************
`define DEM_RST_WORD 32'h0000_0000
`define DEM_RST_G0 21'h00_0000
`define DEM_RST_G1 13'h0000
`define DEM_RST_VCID 2'h0
`define DEM_RST_CODE 4'h0

`endif

// ===== include/dem_pkg.sv
// ************************************************************
// Shared types
// ************************************************************
package dem_pkg;
  // Shadow copy sequencer states
  typedef enum logic [0:0] {
    SH_IDLE,
    SH_COPY
  } dem_shadow_state_t;
endpackage

// ===== src/dem_sync.sv
`timescale 1ns/100ps
// ************************************************************
// Two-flop synchroniser for a level from outside the clock
// ************************************************************
module dem_sync (
  // Clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // Asynchronous level in, synchronised level out
  input wire logic async_in,
  output logic sync_out
);
  logic meta_reg;

  // First stage feeds only the second stage
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      meta_reg <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule

// ===== src/dem_regbank.sv
`timescale 1ns/100ps
`include "dem_regs.svh"

module dem_regbank (
  // Clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // APB register port
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`DEM_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Error events, one-cycle pulses from core logic
  input wire logic [`DEM_PHY_W-1:0] lane0_phy_err,
  input wire logic [`DEM_ACK_W-1:0] ack_err_report,
  input wire logic highspeed_tx_timeout_flag,
  input wire logic lowpower_rx_timeout_flag,
  input wire logic ecc_single_evt,
  input wire logic ecc_multi_evt,
  input wire logic crc_evt,
  input wire logic pkt_size_evt,
  input wire logic eotp_missing_evt,
  input wire logic pixel_fifo_ovf_evt,
  input wire logic cmd_fifo_wr_ovf_evt,
  input wire logic pld_fifo_wr_ovf_evt,
  input wire logic pld_send_unf_evt,
  input wire logic pld_read_unf_evt,
  input wire logic pld_recv_ovf_evt,
  // External shadow request pin
  input wire logic shadow_req_pin,
  // Interrupt and active pixel-port configuration
  output logic error_irq,
  output logic [`DEM_VCID_W-1:0] active_vcid,
  output logic [`DEM_CODE_W-1:0] active_color_code,
  output logic active_loose_18bit
);

  // ************************************************************
  // Declarations
  // ************************************************************
  logic [`DEM_G0_W-1:0] status0_reg, status0_next, mask0_reg, evt0, clr0;
  logic [`DEM_G1_W-1:0] status1_reg, status1_next, mask1_reg, evt1, clr1;
  logic sh_en_reg, sh_pin_reg, sh_req_reg, sh_req_next;
  logic [`DEM_VCID_W-1:0] vcid_reg, aux_vcid_reg;
  logic [`DEM_CODE_W-1:0] code_reg, aux_code_reg;
  logic loose_reg, aux_loose_reg;
  logic [31:0] rd_word;
  logic rd_err, pin_sync, pin_sync_d_reg, pin_rise, copy_trig;
  logic setup_ph, acc_ph, wr_acc, rd_acc, pending, sw_req_set;
  logic wr_mask0, wr_mask1, wr_force0, wr_force1, wr_shadow, wr_vcid, wr_color;
  dem_pkg::dem_shadow_state_t sh_state_reg, sh_state_next;
  // Address match, shared by read mux and write strobes
  function automatic logic hit(input logic [`DEM_ADDR_W-1:0] a, off);
    hit = (a == off);
  endfunction

  // ************************************************************
  // APB phases and write strobes
  // ************************************************************
  assign setup_ph = psel & ~penable;
  assign acc_ph = psel & penable & pready;
  assign wr_acc = acc_ph & pwrite & ~pslverr;
  assign rd_acc = acc_ph & ~pwrite & ~pslverr;
  assign wr_mask0 = wr_acc & hit(paddr, `DEM_OFF_MASK0);
  assign wr_mask1 = wr_acc & hit(paddr, `DEM_OFF_MASK1);
  assign wr_force0 = wr_acc & hit(paddr, `DEM_OFF_FORCE0);
  assign wr_force1 = wr_acc & hit(paddr, `DEM_OFF_FORCE1);
  assign wr_shadow = wr_acc & hit(paddr, `DEM_OFF_SHADOW);
  assign wr_vcid = wr_acc & hit(paddr, `DEM_OFF_VCID);
  assign wr_color = wr_acc & hit(paddr, `DEM_OFF_COLOR);
  // Read mux; force registers have no storage and read as zero
  assign rd_word =
    hit(paddr, `DEM_OFF_STATUS0) ? {11'h000, status0_reg} :
    hit(paddr, `DEM_OFF_STATUS1) ? {19'h0_0000, status1_reg} :
    hit(paddr, `DEM_OFF_MASK0) ? {11'h000, mask0_reg} :
    hit(paddr, `DEM_OFF_MASK1) ? {19'h0_0000, mask1_reg} :
    hit(paddr, `DEM_OFF_SHADOW) ?
      {15'h0000, sh_pin_reg, 7'h00, sh_req_reg, 7'h00, sh_en_reg} :
    hit(paddr, `DEM_OFF_VCID) ? {30'h0000_0000, vcid_reg} :
    hit(paddr, `DEM_OFF_COLOR) ? {23'h00_0000, loose_reg, 4'h0, code_reg} :
    `DEM_RST_WORD;
  assign rd_err = !(paddr inside {`DEM_OFF_STATUS0, `DEM_OFF_STATUS1,
    `DEM_OFF_MASK0, `DEM_OFF_MASK1, `DEM_OFF_FORCE0, `DEM_OFF_FORCE1,
    `DEM_OFF_SHADOW, `DEM_OFF_VCID, `DEM_OFF_COLOR});
  // Answer built in setup so every bus output leaves a flop
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      prdata <= `DEM_RST_WORD;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      prdata <= setup_ph ? rd_word : `DEM_RST_WORD;
      pready <= setup_ph;
      pslverr <= setup_ph & rd_err;
    end
  end

  // ************************************************************
  // Error status groups
  // ************************************************************
  // Group zero: lane PHY errors above the acknowledge report
  assign evt0 = {lane0_phy_err, ack_err_report};
  // Group one: each source to its own bit
  assign evt1[`DEM_E1_HS_TO] = highspeed_tx_timeout_flag;
  assign evt1[`DEM_E1_LP_TO] = lowpower_rx_timeout_flag;
  assign evt1[`DEM_E1_ECC_SINGLE] = ecc_single_evt;
  assign evt1[`DEM_E1_ECC_MULTI] = ecc_multi_evt;
  assign evt1[`DEM_E1_CRC] = crc_evt;
  assign evt1[`DEM_E1_PKT_SIZE] = pkt_size_evt;
  assign evt1[`DEM_E1_EOTP] = eotp_missing_evt;
  assign evt1[`DEM_E1_PIX_OVF] = pixel_fifo_ovf_evt;
  assign evt1[`DEM_E1_CMD_WR] = cmd_fifo_wr_ovf_evt;
  assign evt1[`DEM_E1_PLD_WR] = pld_fifo_wr_ovf_evt;
  assign evt1[`DEM_E1_PLD_SEND] = pld_send_unf_evt;
  assign evt1[`DEM_E1_PLD_RD] = pld_read_unf_evt;
  assign evt1[`DEM_E1_PLD_RECV] = pld_recv_ovf_evt;
  // Clear on read only the bits software actually saw in prdata,
  // so an event landing between setup and access is not lost
  assign clr0 = (rd_acc & hit(paddr, `DEM_OFF_STATUS0)) ?
                prdata[`DEM_G0_W-1:0] : `DEM_RST_G0;
  assign clr1 = (rd_acc & hit(paddr, `DEM_OFF_STATUS1)) ?
                prdata[`DEM_G1_W-1:0] : `DEM_RST_G1;
  // Set and force win over clear
  assign status0_next = (status0_reg & ~clr0) | evt0 |
    (wr_force0 ? pwdata[`DEM_G0_W-1:0] : `DEM_RST_G0);
  assign status1_next = (status1_reg & ~clr1) | evt1 |
    (wr_force1 ? pwdata[`DEM_G1_W-1:0] : `DEM_RST_G1);
  // Unmasked pending error drives the interrupt
  assign pending = (|(status0_reg & mask0_reg)) |
                   (|(status1_reg & mask1_reg));
  // Status, masks and interrupt flop
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      status0_reg <= `DEM_RST_G0;
      status1_reg <= `DEM_RST_G1;
      mask0_reg <= `DEM_RST_G0;
      mask1_reg <= `DEM_RST_G1;
      error_irq <= 1'b0;
    end else begin
      status0_reg <= status0_next;
      status1_reg <= status1_next;
      if (wr_mask0) begin
        mask0_reg <= pwdata[`DEM_G0_W-1:0];
      end
      if (wr_mask1) begin
        mask1_reg <= pwdata[`DEM_G1_W-1:0];
      end
      error_irq <= pending;
    end
  end

  // ************************************************************
  // Shadow control and pixel-port configuration
  // ************************************************************
  dem_sync u_pin_sync (
    .core_clk(core_clk),
    .resetn(resetn),
    .async_in(shadow_req_pin),
    .sync_out(pin_sync)
  );
  // Edge on the synchronised pin, never the first stage
  assign pin_rise = pin_sync & ~pin_sync_d_reg;
  // Software request only counts outside pin mode
  assign sw_req_set = wr_shadow & pwdata[`DEM_SH_REQ_BIT] &
                      ~pwdata[`DEM_SH_PIN_BIT];
  assign copy_trig = sh_pin_reg ? pin_rise : sh_req_reg;
  // Sequencer: one copy cycle per request
  always_comb begin
    sh_state_next = sh_state_reg;
    case (sh_state_reg)
      dem_pkg::SH_IDLE: begin
        if (copy_trig) begin
          sh_state_next = dem_pkg::SH_COPY;
        end
      end
      dem_pkg::SH_COPY: sh_state_next = dem_pkg::SH_IDLE;
      default: sh_state_next = dem_pkg::SH_IDLE;
    endcase
  end
  // Request bit: a new write wins over the hardware clear
  always_comb begin
    sh_req_next = sh_req_reg;
    if (sh_state_reg == dem_pkg::SH_COPY) begin
      sh_req_next = 1'b0;
    end
    if (wr_shadow) begin
      sh_req_next = sw_req_set | (sh_req_next & ~pwdata[`DEM_SH_PIN_BIT]);
    end
  end
  // Control register, direct config and auxiliary copy
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      sh_state_reg <= dem_pkg::SH_IDLE;
      sh_en_reg <= 1'b0;
      sh_pin_reg <= 1'b0;
      sh_req_reg <= 1'b0;
      pin_sync_d_reg <= 1'b0;
      vcid_reg <= `DEM_RST_VCID;
      code_reg <= `DEM_RST_CODE;
      loose_reg <= 1'b0;
      aux_vcid_reg <= `DEM_RST_VCID;
      aux_code_reg <= `DEM_RST_CODE;
      aux_loose_reg <= 1'b0;
    end else begin
      sh_state_reg <= sh_state_next;
      sh_req_reg <= sh_req_next;
      pin_sync_d_reg <= pin_sync;
      if (wr_shadow) begin
        sh_en_reg <= pwdata[`DEM_SH_EN_BIT];
        sh_pin_reg <= pwdata[`DEM_SH_PIN_BIT];
      end
      if (wr_vcid) begin
        vcid_reg <= pwdata[`DEM_VCID_W-1:0];
      end
      if (wr_color) begin
        code_reg <= pwdata[`DEM_CODE_W-1:0];
        loose_reg <= pwdata[`DEM_LOOSE_BIT];
      end
      if (sh_state_reg == dem_pkg::SH_COPY) begin
        aux_vcid_reg <= vcid_reg;
        aux_code_reg <= code_reg;
        aux_loose_reg <= loose_reg;
      end
    end
  end
  // Active set selection, registered to keep outputs glitch free
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      active_vcid <= `DEM_RST_VCID;
      active_color_code <= `DEM_RST_CODE;
      active_loose_18bit <= 1'b0;
    end else begin
      active_vcid <= sh_en_reg ? aux_vcid_reg : vcid_reg;
      active_color_code <= sh_en_reg ? aux_code_reg : code_reg;
      active_loose_18bit <= sh_en_reg ? aux_loose_reg : loose_reg;
    end
  end

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  // Interrupt follows unmasked status one cycle later
  property p_irq_follows;
    ##1 (error_irq == $past(pending));
  endproperty
  a_irq_follows: assert property (p_irq_follows)
    else $error("interrupt does not follow masked status");
  // Group one events always land in status
  property p_evt1_sets;
    (evt1 != `DEM_RST_G1) |=> ((status1_reg & $past(evt1)) == $past(evt1));
  endproperty
  a_evt1_sets: assert property (p_evt1_sets)
    else $error("group one event lost");
  // Group zero events always land in status
  property p_evt0_sets;
    (evt0 != `DEM_RST_G0) |=> ((status0_reg & $past(evt0)) == $past(evt0));
  endproperty
  a_evt0_sets: assert property (p_evt0_sets)
    else $error("group zero event lost");
  // Group one force write raises the written bits
  property p_force_sets;
    wr_force1 |=>
      ((status1_reg & $past(pwdata[`DEM_G1_W-1:0])) ==
       $past(pwdata[`DEM_G1_W-1:0]));
  endproperty
  a_force_sets: assert property (p_force_sets)
    else $error("force write did not raise status");
  // Mask one holds what was written
  property p_mask1_wr;
    wr_mask1 |=> (mask1_reg == $past(pwdata[`DEM_G1_W-1:0]));
  endproperty
  a_mask1_wr: assert property (p_mask1_wr)
    else $error("mask one write lost");
  // Masked status alone never raises the interrupt
  property p_mask0_gate;
    ((status0_reg & mask0_reg) == `DEM_RST_G0) &&
    ((status1_reg & mask1_reg) == `DEM_RST_G1) |=> !error_irq;
  endproperty
  a_mask0_gate: assert property (p_mask0_gate)
    else $error("masked status raised interrupt");
  // Pin mode ignores the software request
  property p_pin_ignores_sw;
    (sh_pin_reg && sh_state_reg == dem_pkg::SH_IDLE && !pin_rise) |=>
      (sh_state_reg == dem_pkg::SH_IDLE);
  endproperty
  a_pin_ignores_sw: assert property (p_pin_ignores_sw)
    else $error("copy started without pin edge");
  // Pin edge in pin mode starts a copy
  property p_pin_trig;
    (sh_pin_reg && pin_rise && sh_state_reg == dem_pkg::SH_IDLE) |=>
      (sh_state_reg == dem_pkg::SH_COPY);
  endproperty
  a_pin_trig: assert property (p_pin_trig)
    else $error("pin edge did not start copy");
  // Software request: copy, then auxiliary holds direct value
  sequence s_sw_req;
    !sh_pin_reg && sh_req_reg && sh_state_reg == dem_pkg::SH_IDLE;
  endsequence
  sequence s_copy_done;
    (sh_state_reg == dem_pkg::SH_COPY) ##1
      (aux_vcid_reg == $past(vcid_reg) && aux_code_reg == $past(code_reg));
  endsequence
  property p_copy_seq;
    s_sw_req |=> s_copy_done;
  endproperty
  a_copy_seq: assert property (p_copy_seq)
    else $error("shadow copy did not happen");
  // Request bit cleared after the copy cycle
  property p_req_clear;
    (sh_state_reg == dem_pkg::SH_COPY && !wr_shadow) |=> !sh_req_reg;
  endproperty
  a_req_clear: assert property (p_req_clear)
    else $error("request bit not cleared after copy");
  // Shadow enable selects the auxiliary set
  property p_shadow_sel;
    sh_en_reg |=> (active_vcid == $past(aux_vcid_reg) &&
                   active_loose_18bit == $past(aux_loose_reg));
  endproperty
  a_shadow_sel: assert property (p_shadow_sel)
    else $error("active set not taken from auxiliary");
  // Direct channel id reaches the output when shadowing is off
  property p_vcid_direct;
    !sh_en_reg |=> (active_vcid == $past(vcid_reg));
  endproperty
  a_vcid_direct: assert property (p_vcid_direct)
    else $error("channel id not driven from register");
  // Loose packing bit follows the colour register write
  property p_loose_wr;
    wr_color |=> (loose_reg == $past(pwdata[`DEM_LOOSE_BIT]));
  endproperty
  a_loose_wr: assert property (p_loose_wr)
    else $error("loose packing bit write lost");
endmodule

// ===== dv/dem_apb_master.sv
`timescale 1ns/100ps
`include "dem_regs.svh"
// ************************************************************
// APB requester standing in for the system processor
// ************************************************************
module dem_apb_master (
  // Clock
  input wire logic core_clk,
  // Request side
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [`DEM_ADDR_W-1:0] paddr,
  output logic [31:0] pwdata,
  // Answer side
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  // Idle bus at time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
  end

  // One transfer; everything held until pready is seen at an edge, for at most 8 edges
  task automatic xfer(input logic w, input logic [`DEM_ADDR_W-1:0] a,
                      input logic [31:0] d, output logic [31:0] q,
                      output logic err, output logic ok);
    int n;
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    ok = 1'b0;
    err = 1'b0;
    q = '0;
    n = 0;
    while (!ok && n < 8) begin
      @(posedge core_clk);
      n++;
      if (pready === 1'b1) begin
        ok = 1'b1;
        q = prdata;
        err = pslverr;
      end
    end
    // Address and data lines flip so a stale value can never pass for a fresh one
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
  endtask
endmodule

// ===== dv/tb_top.sv
`timescale 1ns/100ps
`include "dem_regs.svh"
// ************************************************************
// Register bank bench
// ************************************************************
module tb_top;
  logic core_clk, resetn, psel, penable, pwrite, pready, pslverr, pin;
  logic [`DEM_ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [4:0] phy;
  logic [15:0] ack;
  logic [12:0] evt1;
  logic error_irq, active_loose_18bit, err, ok;
  logic [1:0] active_vcid;
  logic [3:0] active_color_code;
  logic [`DEM_ADDR_W-1:0] rst_regs [6];
  int n_errors, checks_done;

  // Free-running 10 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  dem_apb_master bus_u (.core_clk, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr);

  dem_regbank dut_u (.core_clk, .resetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .lane0_phy_err(phy),
    .ack_err_report(ack), .highspeed_tx_timeout_flag(evt1[0]),
    .lowpower_rx_timeout_flag(evt1[1]), .ecc_single_evt(evt1[2]),
    .ecc_multi_evt(evt1[3]), .crc_evt(evt1[4]), .pkt_size_evt(evt1[5]),
    .eotp_missing_evt(evt1[6]), .pixel_fifo_ovf_evt(evt1[7]),
    .cmd_fifo_wr_ovf_evt(evt1[8]), .pld_fifo_wr_ovf_evt(evt1[9]),
    .pld_send_unf_evt(evt1[10]), .pld_read_unf_evt(evt1[11]),
    .pld_recv_ovf_evt(evt1[12]), .shadow_req_pin(pin), .error_irq,
    .active_vcid, .active_color_code, .active_loose_18bit);

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  task automatic end_sim();
    $display("mismatches %0d comparisons %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // Bus access; a missing ready ends the run
  task automatic acc(input logic w, input logic [`DEM_ADDR_W-1:0] a,
                     input logic [31:0] d);
    bus_u.xfer(w, a, d, q, err, ok);
    if (!ok) begin
      n_errors++;
      $display("unexpected at %0t: no ready", $time);
      end_sim();
    end
  endtask

  task automatic wr(input logic [`DEM_ADDR_W-1:0] a, input logic [31:0] d);
    acc(1'b1, a, d);
    chk({31'h0, err}, 32'h0);
  endtask

  task automatic rd(input logic [`DEM_ADDR_W-1:0] a, input logic [31:0] e);
    acc(1'b0, a, 32'h0);
    chk(q, e);
  endtask

  // Active pixel-port configuration packed as loose, code, channel
  function automatic logic [31:0] act();
    return {25'h0, active_loose_18bit, active_color_code, active_vcid};
  endfunction

  // Main sequence
  initial begin
    resetn = 1'b0;
    phy = '0;
    ack = '0;
    evt1 = '0;
    pin = 1'b0;
    rst_regs = '{`DEM_OFF_MASK1, `DEM_OFF_FORCE0, `DEM_OFF_FORCE1,
                 `DEM_OFF_SHADOW, `DEM_OFF_VCID, `DEM_OFF_COLOR};
    repeat (16) @(posedge core_clk);
    resetn <= 1'b1;
    foreach (rst_regs[k]) rd(rst_regs[k], 32'h0);
    acc(1'b0, 12'h004, 32'h0);
    chk({31'h0, err}, 32'h1);
    // Each group one event lands alone in its own bit
    for (int i = 0; i < 13; i++) begin
      @(posedge core_clk);
      evt1 <= 13'h1 << i;
      @(posedge core_clk);
      evt1 <= '0;
      rd(`DEM_OFF_STATUS1, 32'h1 << i);
    end
    // Two complementary lane and acknowledge patterns
    for (int j = 0; j < 2; j++) begin
      @(posedge core_clk);
      {phy, ack} <= j ? ~21'h15A5A5 : 21'h15A5A5;
      @(posedge core_clk);
      {phy, ack} <= '0;
      rd(`DEM_OFF_STATUS0, j ? 32'h0A5A5A : 32'h15A5A5);
    end
    // Masked force keeps the interrupt low, unmasking raises it
    wr(`DEM_OFF_FORCE1, 32'h10);
    repeat (3) @(posedge core_clk);
    chk({31'h0, error_irq}, 32'h0);
    wr(`DEM_OFF_MASK1, 32'hFFFFFFFF);
    rd(`DEM_OFF_MASK1, 32'h1FFF);
    repeat (2) @(posedge core_clk);
    chk({31'h0, error_irq}, 32'h1);
    rd(`DEM_OFF_STATUS1, 32'h10);
    repeat (2) @(posedge core_clk);
    chk({31'h0, error_irq}, 32'h0);
    wr(`DEM_OFF_MASK0, 32'hFFFFFFFF);
    rd(`DEM_OFF_MASK0, 32'h1FFFFF);
    wr(`DEM_OFF_FORCE0, 32'h100001);
    repeat (2) @(posedge core_clk);
    chk({31'h0, error_irq}, 32'h1);
    rd(`DEM_OFF_FORCE0, 32'h0);
    rd(`DEM_OFF_STATUS0, 32'h100001);
    // Direct configuration, then a software shadow copy
    wr(`DEM_OFF_VCID, 32'h1);
    wr(`DEM_OFF_COLOR, 32'hFFFFFFFF);
    rd(`DEM_OFF_COLOR, 32'h10F);
    repeat (2) @(posedge core_clk);
    chk(act(), 32'h7D);
    wr(`DEM_OFF_SHADOW, 32'h101);
    repeat (4) @(posedge core_clk);
    rd(`DEM_OFF_SHADOW, 32'h1);
    wr(`DEM_OFF_VCID, 32'h2);
    wr(`DEM_OFF_COLOR, 32'h3);
    repeat (2) @(posedge core_clk);
    chk(act(), 32'h7D);
    // Pin mode: software request ignored, pin edge copies
    wr(`DEM_OFF_SHADOW, 32'h10101);
    repeat (6) @(posedge core_clk);
    rd(`DEM_OFF_SHADOW, 32'h10001);
    chk(act(), 32'h7D);
    @(posedge core_clk);
    pin <= 1'b1;
    repeat (8) @(posedge core_clk);
    chk(act(), 32'h0E);
    pin <= 1'b0;
    end_sim();
  end
endmodule
